// ### pkg/lps_pkg.sv
package lps_pkg;

    // Register addresses
    localparam logic [11:0] ADDR_DUAL_SEL    = 12'h008;
    localparam logic [11:0] ADDR_IRQ_EN_A    = 12'h021;
    localparam logic [11:0] ADDR_IRQ_EN_B    = 12'h022;
    localparam logic [11:0] ADDR_IRQ_ST_A    = 12'h025;
    localparam logic [11:0] ADDR_IRQ_ST_B    = 12'h026;
    localparam logic [11:0] ADDR_TOL_WIN     = 12'h034;
    localparam logic [11:0] ADDR_ERR_SNAP    = 12'h038;
    localparam logic [11:0] ADDR_FLAG_SNAP   = 12'h039;
    localparam logic [11:0] ADDR_ALIGN_CTRL  = 12'h03a;
    localparam logic [11:0] ADDR_ALIGN_STAT  = 12'h03b;
    localparam logic [11:0] ADDR_ERR_LIVE    = 12'h03c;
    localparam logic [11:0] ADDR_FLAG_LIVE   = 12'h03d;
    localparam logic [11:0] ADDR_SUBCL_GLB   = 12'h301;
    localparam logic [11:0] ADDR_SUBCL_LINK  = 12'h458;

    // Control register fields
    localparam int CTRL_ENABLE_BIT   = 7;
    localparam int CTRL_ARM_BIT      = 6;
    localparam int CTRL_STKCLR_BIT   = 5;
    localparam int MODE_MSB          = 3;

    // Status register fields
    localparam int STAT_BUSY_BIT     = 7;
    localparam int STAT_LOCK_BIT     = 3;
    localparam int STAT_ROT_BIT      = 2;
    localparam int STAT_WLIM_BIT     = 1;
    localparam int STAT_TRIP_BIT     = 0;

    // Side flags: low side on bit 7, high side on bit 6
    localparam int FLAG_LOW_BIT      = 7;
    localparam int FLAG_HIGH_BIT     = 6;

    // Field widths
    localparam int TOL_W             = 3;
    localparam int SUBCL_W           = 3;
    localparam int SUBCL_LINK_LSB    = 5;
    localparam int SNAP_ERR_W        = 4;
    localparam int IRQ_W             = 4;

    // Sync processing modes
    localparam logic [3:0] MODE_ONESHOT  = 4'h1;
    localparam logic [3:0] MODE_CONT     = 4'h2;
    localparam logic [3:0] MODE_MONITOR  = 4'h9;

    localparam logic [2:0] SUBCLASS_1    = 3'h1;

    localparam logic [7:0] REG_RESET     = 8'h00;

    // Timing defaults in DAC clock cycles
    localparam int LMFC_PERIOD_DEF   = 32;
    localparam int ROT_CYCLES_DEF    = 8;
    localparam int RX_DELAY_DEF      = 0;

    typedef enum logic [0:0] {
        ST_READY,
        ST_ROTATE
    } lps_state_t;

endpackage

// ### verilog/lps_lmfc_sync.sv
`timescale 1ns/100ps
// Functional notes
// - Mode codes 0x1 one-shot, 0x2 continuous, 0x9 monitor.
// - Compare LMFC phase with SYSREF or processing clock.
// - Out-of-phase check rotates the LMFC into alignment.
// - One-shot checks first armed edge, adjusts beyond window.
// - Continuous checks every edge, no arming needed.
// - Edges ignored while a rotation is underway.
// - Continuous realigns only when error exceeds tolerance.
// - Arm self-clears on edge; in continuous it only sets once_ff.
// - Monitor aligns once, then only measures later edges.
// - Live error zero after alignment, else DAC cycles.
// - Error beyond window sets low or high flag.
// - Alignment snapshots last error nibble and flags.
// - Window code n means plus/minus n, zero means half.
// - Busy reads zero once sync work is finished.
// - Lock and window-exceeded update on every check.
// - Rotation and edge-seen sticky until sticky clear.
// - Dual A interrupt enable and W1C status, four events.
// - Dual B interrupt enable and W1C status, four events.
// - Subclass 0 or 1 in global and link fields.
// - Per-link receive LMFC delayed from aligned LMFC.
// - SYSREF active high, sampled on clock rising edge.
module lps_lmfc_sync
    import lps_pkg::*;
#(
    parameter int LMFC_PERIOD = LMFC_PERIOD_DEF,
    parameter int ROT_CYCLES  = ROT_CYCLES_DEF,
    parameter int RX_DELAY    = RX_DELAY_DEF
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Alignment sources
    input  wire logic        sysref_i,
    input  wire logic        pclk_tick_i,
    // Register port
    input  wire logic [11:0] reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // LMFC and interrupt outputs per dual
    output logic      [1:0]  lmfc_edge_o,
    output logic      [1:0]  lmfc_rx_o,
    output logic      [1:0]  irq_o
);

    localparam int CW = $clog2(LMFC_PERIOD);
    localparam int RW = $clog2(ROT_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(LMFC_PERIOD - 1);
    localparam logic [CW-1:0] CNT_HALF = CW'(LMFC_PERIOD / 2);
    localparam logic [CW-1:0] CNT_RX   = CW'(RX_DELAY);
    localparam logic [7:0]    PERIOD8  = 8'(LMFC_PERIOD);

    // Registers
    logic [1:0]          dual_sel_ff;
    logic [IRQ_W-1:0]    irq_en_ff [2];
    logic [IRQ_W-1:0]    irq_st_ff [2];
    logic [TOL_W-1:0]    tol_ff;
    logic [SNAP_ERR_W-1:0] snap_err_ff;
    logic [1:0]          snap_flag_ff;
    logic                enable_ff;
    logic                arm_ff;
    logic [3:0]          mode_ff;
    logic                lock_ff;
    logic                rot_seen_ff;
    logic                wlim_ff;
    logic                edge_seen_ff;
    logic [7:0]          err_live_ff;
    logic [1:0]          flag_live_ff;
    logic [SUBCL_W-1:0]  subcl_glb_ff;
    logic [SUBCL_W-1:0]  subcl_link_ff;
    logic                once_ff;
    logic [7:0]          rdata_ff;
    logic [1:0]          irq_ff;
    logic [1:0]          edge_out_ff;
    logic [1:0]          rx_out_ff;

    // LMFC and sync machine
    logic [CW-1:0]       cnt_ff [2];
    lps_state_t          state_ff;
    logic [RW-1:0]       rot_cnt_ff;
    logic                sref_s1_ff;
    logic                sref_s2_ff;
    logic                sref_s3_ff;

    logic                ctrl_wr;
    logic                align_edge;
    logic                edge_ok;
    logic                check_w;
    logic                align_w;
    logic                exceed_w;
    logic [CW-1:0]       meas_cnt;
    logic [7:0]          err_w;
    logic [7:0]          mag_w;
    logic [IRQ_W-1:0]    irq_evt;

    assign ctrl_wr = reg_wr_i && (reg_addr_i == ADDR_ALIGN_CTRL);

    // SYSREF is a pin: two stages before the edge detector
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sref_s1_ff <= 1'b0;
            sref_s2_ff <= 1'b0;
            sref_s3_ff <= 1'b0;
        end else begin
            sref_s1_ff <= sysref_i;
            sref_s2_ff <= sref_s1_ff;
            sref_s3_ff <= sref_s2_ff;
        end
    end

    // Rising edge of active-high SYSREF in subclass 1
    assign align_edge = (subcl_glb_ff == SUBCLASS_1) ?
                        (sref_s2_ff && !sref_s3_ff) : pclk_tick_i;

    // Edges arriving mid-rotation are dropped
    assign edge_ok = align_edge && enable_ff && (state_ff == ST_READY);

    // Measure on dual A unless only dual B is selected
    assign meas_cnt = (dual_sel_ff == 2'b10) ? cnt_ff[1] : cnt_ff[0];

    // Signed distance from the nearest LMFC edge
    assign err_w = (meas_cnt < CNT_HALF) ? 8'(meas_cnt)
                                         : 8'(meas_cnt) - PERIOD8;
    assign mag_w = err_w[7] ? (8'h00 - err_w) : err_w;

    // Code 0 tolerates only a half cycle, so any whole error trips
    assign exceed_w = (mag_w > 8'(tol_ff));

    always_comb begin
        check_w = 1'b0;
        align_w = 1'b0;
        if (edge_ok) begin
            unique case (mode_ff)
                MODE_ONESHOT: begin
                    check_w = arm_ff;
                    align_w = arm_ff && exceed_w;
                end
                MODE_CONT: begin
                    check_w = 1'b1;
                    align_w = exceed_w;
                end
                MODE_MONITOR: begin
                    check_w = arm_ff || once_ff;
                    align_w = arm_ff && exceed_w;
                end
                default: begin
                    check_w = 1'b0;
                    align_w = 1'b0;
                end
            endcase
        end
    end

    // Rotation holds off new edges for a fixed settling time
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff   <= ST_READY;
            rot_cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                ST_READY: begin
                    if (align_w) begin
                        state_ff   <= ST_ROTATE;
                        rot_cnt_ff <= RW'(ROT_CYCLES - 1);
                    end
                end
                ST_ROTATE: begin
                    if (rot_cnt_ff == '0) begin
                        state_ff <= ST_READY;
                    end else begin
                        rot_cnt_ff <= rot_cnt_ff - 1'b1;
                    end
                end
            endcase
        end
    end

    // LMFC counters; a rotation restarts the selected duals on the edge
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff[0] <= '0;
            cnt_ff[1] <= '0;
        end else begin
            for (int d = 0; d < 2; d++) begin
                if (align_w && dual_sel_ff[d]) begin
                    cnt_ff[d] <= CW'(1);
                end else if (cnt_ff[d] == CNT_LAST) begin
                    cnt_ff[d] <= '0;
                end else begin
                    cnt_ff[d] <= cnt_ff[d] + 1'b1;
                end
            end
        end
    end

    // LMFC edge and delayed receive LMFC per link
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            edge_out_ff <= 2'b00;
            rx_out_ff   <= 2'b00;
        end else begin
            for (int d = 0; d < 2; d++) begin
                edge_out_ff[d] <= (cnt_ff[d] == '0);
                rx_out_ff[d]   <= (cnt_ff[d] == CNT_RX);
            end
        end
    end

    // Control register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_ff <= 1'b0;
            arm_ff    <= 1'b0;
            mode_ff   <= '0;
        end else begin
            if (ctrl_wr) begin
                enable_ff <= reg_wdata_i[CTRL_ENABLE_BIT];
                mode_ff   <= reg_wdata_i[MODE_MSB:0];
            end
            // Accepted edge clears arm; in continuous it steers no check or
            // alignment, but an armed checked edge still sets once_ff
            if (edge_ok && arm_ff) begin
                arm_ff <= 1'b0;
            end else if (ctrl_wr) begin
                arm_ff <= reg_wdata_i[CTRL_ARM_BIT];
            end
        end
    end

    // Monitor phase after the first armed checked edge; a control write clearing enable restarts it
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            once_ff <= 1'b0;
        end else if (check_w && arm_ff) begin
            once_ff <= 1'b1;
        end else if (ctrl_wr && !reg_wdata_i[CTRL_ENABLE_BIT]) begin
            once_ff <= 1'b0;
        end
    end

    // Live error and side flags
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_live_ff  <= '0;
            flag_live_ff <= 2'b00;
        end else if (align_w) begin
            err_live_ff  <= '0;
            flag_live_ff <= 2'b00;
        end else if (check_w) begin
            err_live_ff  <= err_w;
            flag_live_ff <= {exceed_w && err_w[7],
                             exceed_w && !err_w[7]};
        end
    end

    // Snapshot of the error being corrected
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            snap_err_ff  <= '0;
            snap_flag_ff <= 2'b00;
        end else if (align_w) begin
            snap_err_ff  <= err_w[SNAP_ERR_W-1:0];
            snap_flag_ff <= {err_w[7], !err_w[7]};
        end
    end

    // Live status; a rotation leaves the pair aligned
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_ff <= 1'b0;
            wlim_ff <= 1'b0;
        end else if (check_w) begin
            lock_ff <= !exceed_w || align_w;
            wlim_ff <= exceed_w;
        end
    end

    // Sticky bits: a new event wins over a same-cycle clear
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rot_seen_ff  <= 1'b0;
            edge_seen_ff <= 1'b0;
        end else begin
            if (align_w) begin
                rot_seen_ff <= 1'b1;
            end else if (ctrl_wr && reg_wdata_i[CTRL_STKCLR_BIT]) begin
                rot_seen_ff <= 1'b0;
            end
            if (check_w) begin
                edge_seen_ff <= 1'b1;
            end else if (ctrl_wr && reg_wdata_i[CTRL_STKCLR_BIT]) begin
                edge_seen_ff <= 1'b0;
            end
        end
    end

    // Event order matches status bits 3..0: lock, rotation, window, edge
    assign irq_evt = {check_w && (!exceed_w || align_w), align_w,
                      check_w && exceed_w, check_w};

    // Interrupt status per dual, write one to clear, set wins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_st_ff[0] <= '0;
            irq_st_ff[1] <= '0;
            irq_ff       <= 2'b00;
        end else begin
            for (int d = 0; d < 2; d++) begin
                logic [11:0]      st_addr;
                logic [IRQ_W-1:0] clr;
                st_addr = (d == 0) ? ADDR_IRQ_ST_A : ADDR_IRQ_ST_B;
                clr     = (reg_wr_i && reg_addr_i == st_addr) ?
                          reg_wdata_i[IRQ_W-1:0] : '0;
                irq_st_ff[d] <= (irq_st_ff[d] & ~clr) |
                                (irq_evt & irq_en_ff[d]);
                irq_ff[d]    <= |irq_st_ff[d];
            end
        end
    end

    // Plain configuration registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dual_sel_ff   <= '0;
            irq_en_ff[0]  <= '0;
            irq_en_ff[1]  <= '0;
            tol_ff        <= '0;
            subcl_glb_ff  <= '0;
            subcl_link_ff <= '0;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_DUAL_SEL:   dual_sel_ff  <= reg_wdata_i[1:0];
                ADDR_IRQ_EN_A:   irq_en_ff[0] <= reg_wdata_i[IRQ_W-1:0];
                ADDR_IRQ_EN_B:   irq_en_ff[1] <= reg_wdata_i[IRQ_W-1:0];
                ADDR_TOL_WIN:    tol_ff       <= reg_wdata_i[TOL_W-1:0];
                ADDR_SUBCL_GLB:  subcl_glb_ff <= reg_wdata_i[SUBCL_W-1:0];
                ADDR_SUBCL_LINK: subcl_link_ff <=
                    reg_wdata_i[SUBCL_LINK_LSB +: SUBCL_W];
                default: begin
                end
            endcase
        end
    end

    // Read data, registered one cycle after the read strobe
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= REG_RESET;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_DUAL_SEL:   rdata_ff <= {6'h00, dual_sel_ff};
                ADDR_IRQ_EN_A:   rdata_ff <= {4'h0, irq_en_ff[0]};
                ADDR_IRQ_EN_B:   rdata_ff <= {4'h0, irq_en_ff[1]};
                ADDR_IRQ_ST_A:   rdata_ff <= {4'h0, irq_st_ff[0]};
                ADDR_IRQ_ST_B:   rdata_ff <= {4'h0, irq_st_ff[1]};
                ADDR_TOL_WIN:    rdata_ff <= {5'h00, tol_ff};
                ADDR_ERR_SNAP:   rdata_ff <= {4'h0, snap_err_ff};
                ADDR_FLAG_SNAP:  rdata_ff <= {snap_flag_ff, 6'h00};
                ADDR_ALIGN_CTRL: rdata_ff <= {enable_ff, arm_ff, 2'b00,
                                              mode_ff};
                // Busy covers a rotation and, while enabled, a pending arm outside continuous mode
                ADDR_ALIGN_STAT: rdata_ff <= {(state_ff == ST_ROTATE) ||
                                              (enable_ff && arm_ff &&
                                               mode_ff != MODE_CONT),
                                              3'b000, lock_ff,
                                              rot_seen_ff, wlim_ff,
                                              edge_seen_ff};
                ADDR_ERR_LIVE:   rdata_ff <= err_live_ff;
                ADDR_FLAG_LIVE:  rdata_ff <= {flag_live_ff, 6'h00};
                ADDR_SUBCL_GLB:  rdata_ff <= {5'h00, subcl_glb_ff};
                ADDR_SUBCL_LINK: rdata_ff <= {subcl_link_ff, 5'h00};
                default:         rdata_ff <= REG_RESET;
            endcase
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign lmfc_edge_o = edge_out_ff;
    assign lmfc_rx_o   = rx_out_ff;
    assign irq_o       = irq_ff;

    arm_self_clear_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (edge_ok && arm_ff) |=> !arm_ff)
        else $error("arm not cleared by edge");

    rotate_ignores_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        align_w |=> (!check_w && state_ff == ST_ROTATE) [*8])
        else $error("edge taken during rotation");

    err_zero_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        align_w |=> (err_live_ff == 8'h00 && flag_live_ff == 2'b00))
        else $error("live error not zero after alignment");

    oneshot_unarmed_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (mode_ff == MODE_ONESHOT && !arm_ff) |-> !check_w)
        else $error("one-shot checked without arm");

    cont_check_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (edge_ok && mode_ff == MODE_CONT) |=> edge_seen_ff)
        else $error("continuous edge not checked");

    window_flag_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (check_w && !align_w && exceed_w) |=>
        (flag_live_ff == {$past(err_w[7]), !$past(err_w[7])}))
        else $error("side flag wrong");

    rotation_phase_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (align_w && dual_sel_ff[0]) |-> ##(LMFC_PERIOD)
        (cnt_ff[0] == '0))
        else $error("LMFC not aligned after rotation");

    monitor_hold_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (mode_ff == MODE_MONITOR && !arm_ff) |-> !align_w)
        else $error("monitor mode rotated without arm");

    sticky_clear_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (ctrl_wr && reg_wdata_i[CTRL_STKCLR_BIT] && !check_w) |=>
        (!edge_seen_ff && !rot_seen_ff))
        else $error("sticky bits not cleared");

    irq_latch_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (check_w && irq_en_ff[0][STAT_TRIP_BIT]) |=> ##1 irq_o[0])
        else $error("dual A interrupt missing");

endmodule

// ### tb/lps_sysref_gen.sv
`timescale 1ns/100ps
module lps_sysref_gen (
    // Clock and control
    input  wire logic       clock_i,
    input  wire logic       run_i,
    input  wire logic [7:0] period_i,
    // SYSREF pin
    output logic            sysref_o
);
    logic [7:0] cnt_ff;
    // Pin held low when stopped, so no stray edge between bursts
    always_ff @(posedge clock_i) begin
        if (!run_i) begin
            cnt_ff   <= 8'h00;
            sysref_o <= 1'b0;
        end else begin
            sysref_o <= (cnt_ff == 8'h00);
            cnt_ff   <= (cnt_ff == 8'h00) ?
                        period_i - 8'h01 : cnt_ff - 8'h01;
        end
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import lps_pkg::*;
    logic        clock_i, rst_n_i, sysref_i, pclk_tick_i, reg_wr_i, reg_rd_i;
    logic [11:0] reg_addr_i;
    logic [7:0]  reg_wdata_i, reg_rdata_o, period, d;
    logic [1:0]  lmfc_edge_o, lmfc_rx_o, irq_o;
    logic        run, rd_d;
    logic [15:0] q[$];
    logic [15:0] n;
    int          err_count, num_checks, cyc;
    lps_lmfc_sync dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .sysref_i(sysref_i), .pclk_tick_i(pclk_tick_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .lmfc_edge_o(lmfc_edge_o), .lmfc_rx_o(lmfc_rx_o), .irq_o(irq_o));
    lps_sysref_gen gen (.clock_i(clock_i), .run_i(run),
        .period_i(period), .sysref_o(sysref_i));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task finish_test;
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clock_i) #1;
        reg_addr_i = a; reg_wdata_i = v; reg_wr_i = 1'b1;
        @(posedge clock_i) #1 reg_wr_i = 1'b0;
    endtask
    // Note expected value and mask; the monitor compares the answer
    task rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clock_i) #1;
        reg_addr_i = a; reg_rd_i = 1'b1; q.push_back({e, m});
        @(posedge clock_i) #1 reg_rd_i = 1'b0;
    endtask
    task ref_wait(input int k);
        @(posedge sysref_i);
        repeat (k) @(posedge clock_i);
    endtask
    // One SYSREF interval of p cycles moves the edge by p-32 cycles
    task shift(input logic [7:0] p);
        @(posedge sysref_i) #1 period = p;
        @(posedge sysref_i) #1 period = 8'h20;
        ref_wait(14);
    endtask
    task done(input string s);
        $display("Test %s done", s);
    endtask
    always @(posedge clock_i) begin
        rd_d <= reg_rd_i;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    always @(negedge clock_i) if (rd_d === 1'b1) begin
        n = q.pop_front();
        `CHK(reg_rdata_o & n[7:0], n[15:8])
    end
    initial begin
        {rst_n_i, pclk_tick_i, reg_wr_i, reg_rd_i, run, rd_d} = '0;
        reg_addr_i = 12'h000; reg_wdata_i = 8'h00; period = 8'h20;
        void'($urandom(19119));
        d = 8'h01 + 8'($urandom % 3);
        repeat (12) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        rd(ADDR_ALIGN_STAT, 8'h00, 8'hff);
        rd(ADDR_TOL_WIN, 8'h00, 8'hff);
        wr(ADDR_TOL_WIN, 8'hff);
        rd(ADDR_TOL_WIN, 8'h07, 8'hff);
        wr(12'h100, 8'h5a);
        rd(12'h100, 8'h00, 8'hff);
        wr(ADDR_DUAL_SEL, 8'h03);
        wr(ADDR_SUBCL_GLB, 8'h01);
        wr(ADDR_SUBCL_LINK, 8'h20);
        rd(ADDR_SUBCL_LINK, 8'h20, 8'hff);
        wr(ADDR_TOL_WIN, 8'h00);
        wr(ADDR_IRQ_EN_A, 8'h01);
        wr(ADDR_IRQ_EN_B, 8'h04);
        done("registers");
        wr(ADDR_ALIGN_CTRL, 8'h82);
        #1 run = 1'b1;
        ref_wait(6);
        wr(ADDR_ALIGN_CTRL, 8'ha2);
        shift(8'h23);
        rd(ADDR_ALIGN_STAT, 8'h0f, 8'hff);
        rd(ADDR_ERR_LIVE, 8'h00, 8'hff);
        rd(ADDR_ERR_SNAP, 8'h03, 8'hff);
        rd(ADDR_FLAG_SNAP, 8'h40, 8'hff);
        `CHK(irq_o, 2'b11)
        rd(ADDR_IRQ_ST_B, 8'h04, 8'hff);
        ref_wait(6);
        wr(ADDR_ALIGN_CTRL, 8'hc2);
        rd(ADDR_ALIGN_CTRL, 8'hc2, 8'hff);
        ref_wait(14);
        rd(ADDR_ALIGN_CTRL, 8'h82, 8'hff);
        rd(ADDR_ALIGN_STAT, 8'h0d, 8'hff);
        // Aligned LMFC edge lands on the cycle the synced SYSREF is taken
        ref_wait(3);
        #1;
        `CHK(lmfc_edge_o, 2'b11)
        `CHK(lmfc_rx_o, 2'b11)
        done("continuous");
        wr(ADDR_ALIGN_CTRL, 8'h00);
        wr(ADDR_ALIGN_CTRL, 8'he9);
        shift(8'h20 - d);
        rd(ADDR_ALIGN_STAT, 8'h03, 8'hff);
        rd(ADDR_ERR_LIVE, 8'h00 - d, 8'hff);
        rd(ADDR_FLAG_LIVE, 8'h80, 8'hff);
        rd(ADDR_ALIGN_CTRL, 8'h89, 8'hff);
        ref_wait(14);
        rd(ADDR_ERR_LIVE, 8'h00 - d, 8'hff);
        done("monitor");
        wr(ADDR_TOL_WIN, 8'h03);
        wr(ADDR_ALIGN_CTRL, 8'h00);
        wr(ADDR_ALIGN_CTRL, 8'ha1);
        wr(ADDR_IRQ_ST_A, 8'h0f);
        wr(ADDR_IRQ_ST_B, 8'h0f);
        repeat (40) @(posedge clock_i);
        rd(ADDR_ALIGN_STAT, 8'h00, 8'h85);
        rd(ADDR_IRQ_ST_A, 8'h00, 8'hff);
        `CHK(irq_o, 2'b00)
        ref_wait(6);
        wr(ADDR_ALIGN_CTRL, 8'hc1);
        rd(ADDR_ALIGN_STAT, 8'h80, 8'h80);
        ref_wait(14);
        rd(ADDR_ALIGN_STAT, 8'h09, 8'hff);
        wr(ADDR_TOL_WIN, 8'h00);
        wr(ADDR_ALIGN_CTRL, 8'he1);
        ref_wait(14);
        rd(ADDR_ALIGN_STAT, 8'h0f, 8'hff);
        rd(ADDR_ERR_SNAP, (8'h00 - d) & 8'h0f, 8'hff);
        rd(ADDR_FLAG_SNAP, 8'h80, 8'hff);
        wr(ADDR_ALIGN_CTRL, 8'ha1);
        ref_wait(14);
        rd(ADDR_ALIGN_STAT, 8'h00, 8'h85);
        done("one-shot");
        repeat (4) @(posedge clock_i);
        finish_test();
    end
endmodule
